// [rtl/sram_addr_unit.sv]
`timescale 1ns/1ps
`include "sram_regs.svh"
// ----------------------------------------
// Overview of operation
// ----------------------------------------
module sram_addr_unit
    import sram_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    input  wire logic                     clkEn,
    input  wire logic                     opValid,
    input  wire sram_op_s                 op,
    input  wire sram_wr_s                 wr,
    output logic [`SRAM_DATA_W-1:0]       rdData,
    output logic [`SRAM_COL_W-1:0]        col,
    output logic [`SRAM_ROW_W-1:0]        row,
    output logic [`SRAM_ROW_W-1:0]        rowBuf,
    output logic [`SRAM_ADDR_W-1:0]       memAddr
);
    // ----------------------------------------
    // mapping
    // ----------------------------------------
    // columns 64 and up fold into the top physical rows; bits 5,4 drop out
    function automatic logic [`SRAM_ADDR_W-1:0] mapAddr(
        input logic [`SRAM_ROW_W-1:0] r,
        input logic [`SRAM_COL_W-1:0] c
    );
        if ((r[3] & r[2]) | c[6]) begin
            mapAddr = {`SRAM_ALT_TOP, r, c[3:0]};
        end else begin
            mapAddr = {r, c[5:0]};
        end
    endfunction

    // ----------------------------------------
    // storage
    // ----------------------------------------
    // 16x64 physical array; scratch lives in the top four rows
    // no reset on the array: clearing every word would need a long sweep
    logic [`SRAM_DATA_W-1:0] mem [0:`SRAM_WORDS-1];
    logic [`SRAM_ADDR_W-1:0] curAddr;
    logic [`SRAM_DATA_W-1:0] curWord;
    logic                    go;

    assign go      = clkEn & opValid;
    assign curAddr = mapAddr(row, col);
    // asynchronous read so loads see the word at the present address
    assign curWord = mem[curAddr];

    always_ff @(posedge clock) begin
        if (clkEn && wr.wrEn) begin
            mem[curAddr] <= wr.wrData;
        end
    end

    // ----------------------------------------
    // column register
    // ----------------------------------------
    // priority: load, clear, step, flip; flip combines with a load result
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            col <= `SRAM_COL_RST;
        end else if (go) begin
            if (op.colFromMem) begin
                col <= curWord ^ {3'h0, op.colFlip3, 3'h0};
            end else if (op.colClr) begin
                col <= `SRAM_COL_RST;
            end else if (op.colInc) begin
                col <= col + 7'h01;
            end else if (op.colDec) begin
                col <= col - 7'h01;
            end else if (op.colFlip3) begin
                col <= col ^ 7'h08;
            end
        end
    end

    // ----------------------------------------
    // row register and holding buffer
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            row <= `SRAM_ROW_RST;
        end else if (go) begin
            if (op.rowFromBuf) begin
                row <= rowBuf;
            end else if (op.rowClr) begin
                row <= `SRAM_ROW_RST;
            end else if (op.rowInc) begin
                row <= row + 4'h1;
            end else if (op.rowDec) begin
                row <= row - 4'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rowBuf <= `SRAM_BUF_RST;
        end else if (go && op.bufFromMem) begin
            rowBuf <= curWord[3:0];
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdData  <= 7'h00;
            memAddr <= 10'h000;
        end else if (clkEn) begin
            rdData  <= curWord;
            memAddr <= curAddr;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_bufLoad;
        go && op.bufFromMem && !op.rowFromBuf;
    endsequence
    sequence s_rowCopy;
        go && op.rowFromBuf;
    endsequence

    a_alt_map_form: assert property (
        ((row[3] & row[2]) | col[6]) |-> curAddr[9:8] == 2'h3
            && curAddr[3:0] == col[3:0] && curAddr[7:4] == row)
        else $error("alternate mapping form wrong");
    a_direct_map_form: assert property (
        (!(row[3] & row[2]) && !col[6]) |-> curAddr == {row, col[5:0]})
        else $error("direct mapping form wrong");
    a_col_step_up: assert property (
        go && op.colInc && !op.colFromMem && !op.colClr
            |=> col == $past(col) + 7'h01)
        else $error("column increment wrong");
    a_row_step_down: assert property (
        go && op.rowDec && !op.rowFromBuf && !op.rowClr && !op.rowInc
            |=> row == $past(row) - 4'h1)
        else $error("row decrement wrong");
    a_col_flip_bit: assert property (
        go && op.colFlip3 && !op.colFromMem && !op.colClr && !op.colInc
            && !op.colDec |=> col == ($past(col) ^ 7'h08))
        else $error("column bit flip wrong");
    a_col_mem_load: assert property (
        go && op.colFromMem && !op.colFlip3 |=> col == $past(curWord))
        else $error("column load from memory wrong");
    // an indirect load spreads over a few instructions, so allow a window
    a_buf_to_row: assert property (
        s_bufLoad ##[1:12] s_rowCopy |=> row == $past(rowBuf))
        else $error("indirect row copy wrong");
    a_buf_mem_load: assert property (
        go && op.bufFromMem |=> rowBuf == $past(curWord[3:0]))
        else $error("buffer load wrong");
    a_freeze_hold: assert property (
        !clkEn |=> $stable(col) && $stable(row) && $stable(rowBuf))
        else $error("state changed while clock enable low");

    // ----------------------------------------
    // clear, step and load checks
    // ----------------------------------------
    // each check masks the higher-priority fields so one winner is seen
    a_row_clear: assert property (
        go && op.rowClr && !op.rowFromBuf |=> row == `SRAM_ROW_RST)
        else $error("row clear wrong");
    a_col_clear: assert property (
        go && op.colClr && !op.colFromMem |=> col == `SRAM_COL_RST)
        else $error("column clear wrong");
    a_row_step_up: assert property (
        go && op.rowInc && !op.rowFromBuf && !op.rowClr
            |=> row == $past(row) + 4'h1)
        else $error("row increment wrong");
    a_col_step_down: assert property (
        go && op.colDec && !op.colFromMem && !op.colClr && !op.colInc
            |=> col == $past(col) - 7'h01)
        else $error("column decrement wrong");
    a_flip_on_load: assert property (
        go && op.colFromMem && op.colFlip3
            |=> col == ($past(curWord) ^ 7'h08))
        else $error("flipped column load wrong");
    a_row_from_buf: assert property (
        s_rowCopy |=> row == $past(rowBuf))
        else $error("row copy from buffer wrong");

    // ----------------------------------------
    // hold and address checks
    // ----------------------------------------
    // no check on read data: words never written read as unknown
    a_buf_hold: assert property (
        !(go && op.bufFromMem) |=> $stable(rowBuf))
        else $error("buffer changed without a load");
    a_idle_hold: assert property (
        !go |=> $stable(col) && $stable(row))
        else $error("address registers moved without an op");
    a_freeze_addr: assert property (
        !clkEn |=> $stable(memAddr))
        else $error("address output moved while clock enable low");
    a_addr_out_reg: assert property (
        clkEn |=> memAddr == $past(curAddr))
        else $error("address output does not follow registers");
    a_screen_rows: assert property (
        !(row[3] & row[2]) && !col[6] |-> curAddr[9:8] != `SRAM_ALT_TOP)
        else $error("screen cell mapped into scratch rows");
    a_scratch_top: assert property (
        (row[3] & row[2]) |-> curAddr[9:6] == 4'hF
            && curAddr[3:0] == col[3:0])
        else $error("scratch row access left the scratch area");
endmodule

// [pkg/sram_regs.svh]
`ifndef SRAM_REGS_SVH
`define SRAM_REGS_SVH
// ----------------------------------------
// sizes and mapping constants
// ----------------------------------------
`define SRAM_WORDS      1024
`define SRAM_DATA_W     7
`define SRAM_ADDR_W     10
`define SRAM_COL_W      7
`define SRAM_ROW_W      4
`define SRAM_COL_RST    7'h00
`define SRAM_ROW_RST    4'h0
`define SRAM_BUF_RST    4'h0
`define SRAM_ALT_TOP    2'h3
`endif

// [pkg/sram_pkg.sv]
package sram_pkg;
    // one instruction's address-unit operations; several may be set at once
    typedef struct packed {
        logic rowClr;
        logic rowInc;
        logic rowDec;
        logic rowFromBuf;
        logic colClr;
        logic colInc;
        logic colDec;
        logic colFlip3;
        logic colFromMem;
        logic bufFromMem;
    } sram_op_s;

    // memory request: write strobe and data
    typedef struct packed {
        logic       wrEn;
        logic [6:0] wrData;
    } sram_wr_s;
endpackage

// [dv/sram_ucode_model.sv]
`timescale 1ns/1ps
module sram_ucode_model
    import sram_pkg::*;
(
    input  wire logic     clock,
    output logic          opValid,
    output sram_op_s      op
);
    initial begin
        opValid = 1'b0;
        op      = '0;
    end
    // each instruction valid for one cycle, then one idle cycle; fields may be combined freely
    task automatic issue(input sram_op_s o);
        @(negedge clock);
        opValid = 1'b1;
        op      = o;
        @(negedge clock);
        opValid = 1'b0;
        op      = '0;
    endtask
endmodule

// [dv/screen_ram_address_mapper_bench.sv]
`timescale 1ns/1ps
`include "sram_regs.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; \
 $display("MISMATCH %s exp %h got %h", n, e, s); end end
module screen_ram_address_mapper_bench
    import sram_pkg::*;
;
    logic        clock;
    logic        rst_n;
    logic        clkEn;
    logic        opValid;
    sram_op_s    op;
    sram_op_s    o;
    sram_wr_s    wr;
    logic [6:0]  rdData;
    logic [6:0]  col;
    logic [3:0]  row;
    logic [3:0]  rowBuf;
    logic [9:0]  memAddr;
    int          err_count;
    int          n_compared;
    sram_addr_unit sram_addr_unit_i (.clock(clock), .rst_n(rst_n),
        .clkEn(clkEn), .opValid(opValid), .op(op), .wr(wr), .rdData(rdData),
        .col(col), .row(row), .rowBuf(rowBuf), .memAddr(memAddr));
    sram_ucode_model sram_ucode_model_i (.clock(clock), .opValid(opValid),
        .op(op));
    function automatic logic [9:0] mapAddr(logic [3:0] r, logic [6:0] c);
        return (r[3] & r[2] | c[6]) ? {2'h3, r, c[3:0]} : {r, c[5:0]};
    endfunction
    // settle time covers the registered address and read paths
    task automatic run(input sram_op_s x);
        sram_ucode_model_i.issue(x);
        repeat (3) @(negedge clock);
    endtask
    task automatic put(input logic [6:0] d);
        wr = '{1'h1, d};
        @(negedge clock);
        wr = '0;
        repeat (2) @(negedge clock);
    endtask
    // indirect load through the holding buffer, staged at word zero
    task automatic go_to(input logic [3:0] r, input logic [6:0] c);
        o = '0; o.rowClr = 1'h1; o.colClr = 1'h1; run(o);
        put({3'h0, r});
        o = '0; o.bufFromMem = 1'h1; run(o);
        `CHK("rowBuf", r, rowBuf)
        put(c);
        o = '0; o.colFromMem = 1'h1; o.rowFromBuf = 1'h1; run(o);
        `CHK("col", c, col)
        `CHK("row", r, row)
        `CHK("memAddr", mapAddr(r, c), memAddr)
    endtask
    task automatic t_reset;
        `CHK("col", 7'h00, col)
        `CHK("row", 4'h0, row)
        `CHK("rowBuf", 4'h0, rowBuf)
        `CHK("memAddr", 10'h000, memAddr)
    endtask
    task automatic t_map;
        logic [10:0] tbl [6] = '{11'h5BF, 11'h605, 11'h2C9, 11'h7FF,
            11'h1AA, 11'h440};
        foreach (tbl[i]) go_to(tbl[i][10:7], tbl[i][6:0]);
        go_to(4'h5, 7'h49);
        put(7'h2A);
        go_to(4'h5, 7'h79);
        `CHK("alias", 7'h2A, rdData)
        put(7'h7F);
        `CHK("rdData", 7'h7F, rdData)
    endtask
    task automatic t_steps;
        go_to(4'hC, 7'h05);
        o = '0; o.colFlip3 = 1'h1; run(o);
        `CHK("col", 7'h0D, col)
        `CHK("memAddr", 10'h3CD, memAddr)
        put(7'h41);
        o = '0; o.colFromMem = 1'h1; o.colFlip3 = 1'h1; run(o);
        `CHK("col", 7'h49, col)
        `CHK("memAddr", 10'h3C9, memAddr)
        go_to(4'h0, 7'h00);
        o = '0; o.rowDec = 1'h1; o.colDec = 1'h1; run(o);
        `CHK("col", 7'h7F, col)
        `CHK("row", 4'hF, row)
        o = '0; o.rowInc = 1'h1; o.colInc = 1'h1; run(o);
        `CHK("col", 7'h00, col)
        `CHK("row", 4'h0, row)
        clkEn = 1'h0;
        run(o);
        clkEn = 1'h1;
        `CHK("col", 7'h00, col)
        `CHK("row", 4'h0, row)
    endtask
    // reset from a busy state, with the clock enable low throughout
    task automatic t_reset_mid;
        go_to(4'h7, 7'h23);
        rst_n = 1'h0;
        clkEn = 1'h0;
        @(negedge clock);
        rst_n = 1'h1;
        @(negedge clock);
        clkEn = 1'h1;
        t_reset();
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    initial begin
        #100000;
        err_count++;
        final_report();
    end
    initial begin
        rst_n = 1'h0;
        clkEn = 1'h1;
        wr    = '0;
        repeat (12) @(negedge clock);
        rst_n = 1'h1;
        @(negedge clock);
        t_reset();
        t_map();
        t_steps();
        t_reset_mid();
        final_report();
    end
endmodule
